//--- inc/prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// ==========================================================
// register offsets (byte addresses on the wishbone slave)
`define PRS_OFF_NIA 8'h00
`define PRS_OFF_CSW 8'h04
`define PRS_OFF_STP 8'h08
`define PRS_OFF_GPR 8'h10
`define PRS_OFF_PAIR 8'h30
`define PRS_OFF_DEC 8'h40
`define PRS_OFF_DADDR 8'h44
// ==========================================================
// status word field positions
`define PRS_CSW_IE 7
`define PRS_CSW_Z 6
`define PRS_CSW_AC 4
`define PRS_CSW_CY 0
// ==========================================================
// reset values and memory map
`define PRS_NIA_RST 16'h0000
`define PRS_CSW_RST 8'h02
`define PRS_RAM_LO 16'hFE80
`define PRS_RAM_HI 16'hFEFF
`define PRS_SFR_LO 16'hFF00
`define PRS_DMEM_LO 16'hFE80
`endif

//--- inc/prs_pkg.sv
package prs_pkg;
	// ==========================================================
	// datapath update bundle from the decoder/alu
	typedef struct packed {
		logic nia_we;
		logic [15:0] nia;
		logic stp_we;
		logic [15:0] stp;
		logic flag_we;
		logic [8:0] result;
		logic [3:0] nib_a;
		logic [3:0] nib_b;
		logic sub;
		logic ie_we;
		logic ie;
		logic gpr_we;
		logic wide;
		logic [2:0] idx;
		logic [15:0] wdata;
	} prs_upd_s;
	// address region classes
	typedef enum logic [2:0] {
		PRS_REG_NONE = 3'b001,
		PRS_REG_RAM = 3'b010,
		PRS_REG_SFR = 3'b100
	} prs_region_e;
	// bus slave states
	typedef enum logic [1:0] {
		PRS_IDLE = 2'b01,
		PRS_ACK = 2'b10
	} prs_bus_e;
	// all state of the register set
	typedef struct packed {
		logic [15:0] nia;
		logic [7:0] csw;
		logic [15:0] stp;
		logic [7:0][7:0] gpr;
		prs_bus_e bus;
		logic [31:0] dat;
		logic err;
		logic [15:0] daddr;
		logic [15:0] rd_byte;
		logic [15:0] rd_pair;
		prs_region_e region;
		logic [7:0] sfr_off;
	} prs_state_s;
endpackage

//--- core/prs_regset.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`include "prs_defs.svh"

module prs_regset
	import prs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// datapath side
	input wire prs_upd_s upd_i,
	input wire logic [2:0] rd_idx_i,
	input wire logic [1:0] rd_pidx_i,
	output logic [15:0] nia_o,
	output logic [7:0] csw_o,
	output logic [15:0] stp_o,
	output logic irq_accept_flag_o,
	output logic [15:0] rd_byte_o,
	output logic [15:0] rd_pair_o,
	output prs_region_e region_o,
	output logic [7:0] sfr_off_o
);
	// ==========================================================
	// helpers
	// pair index maps to low byte 2p and high byte 2p+1
	function automatic logic [15:0] pair_rd(input logic [7:0][7:0] g, input logic [1:0] p);
		pair_rd = {g[{p, 1'b1}], g[{p, 1'b0}]};
	endfunction

	// classify a data address in the 64 KB space
	function automatic prs_region_e classify(input logic [15:0] a);
		if (a >= `PRS_SFR_LO) begin
			classify = PRS_REG_SFR;
		end else if (a >= `PRS_DMEM_LO) begin
			classify = PRS_REG_RAM;
		end else begin
			classify = PRS_REG_NONE;
		end
	endfunction

	// expand byte selects to a bit mask
	function automatic logic [31:0] sel_mask(input logic [3:0] s);
		sel_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	prs_state_s q;
	prs_state_s next_q;
	logic [31:0] wmask;
	logic [31:0] rdata;
	logic [31:0] cur;
	logic hit;
	logic [7:0] csw_n;
	logic [4:0] nib_sum;
	logic [2:0] bidx;
	logic [1:0] pidx;

	// ==========================================================
	// next state
	always_comb begin
		next_q = q;
		wmask = sel_mask(sel_i);
		rdata = 32'h0000_0000;
		hit = 1'b1;
		cur = 32'h0000_0000;
		csw_n = q.csw;
		nib_sum = 5'h00;
		// byte window starts at 10h, so flip bit 4 to get index 0 at the window base
		bidx = adr_i[4:2] ^ 3'h4;
		pidx = adr_i[3:2];
		// datapath updates first; the bus write below overrides on a tie
		if (upd_i.nia_we) begin
			next_q.nia = upd_i.nia;
		end
		if (upd_i.stp_we) begin
			next_q.stp = upd_i.stp;
		end
		if (upd_i.flag_we) begin
			csw_n[`PRS_CSW_Z] = (upd_i.result[7:0] == 8'h00);
			// nibble add or subtract exposes the bit-3 carry/borrow in bit 4
			if (upd_i.sub) begin
				nib_sum = {1'b0, upd_i.nib_a} - {1'b0, upd_i.nib_b};
			end else begin
				nib_sum = {1'b0, upd_i.nib_a} + {1'b0, upd_i.nib_b};
			end
			csw_n[`PRS_CSW_AC] = nib_sum[4];
			csw_n[`PRS_CSW_CY] = upd_i.result[8];
		end
		if (upd_i.ie_we) begin
			csw_n[`PRS_CSW_IE] = upd_i.ie;
		end
		next_q.csw = csw_n;
		if (upd_i.gpr_we) begin
			if (upd_i.wide) begin
				next_q.gpr[{upd_i.idx[1:0], 1'b0}] = upd_i.wdata[7:0];
				next_q.gpr[{upd_i.idx[1:0], 1'b1}] = upd_i.wdata[15:8];
			end else begin
				next_q.gpr[upd_i.idx] = upd_i.wdata[7:0];
			end
		end
		// registered read ports; same storage for byte and pair indices
		next_q.rd_byte = {8'h00, q.gpr[rd_idx_i]};
		next_q.rd_pair = pair_rd(q.gpr, rd_pidx_i);
		next_q.region = classify(q.daddr);
		next_q.sfr_off = q.daddr[7:0];
		// read mux for the bus
		if (adr_i == `PRS_OFF_NIA) begin
			cur = {16'h0000, q.nia};
		end else if (adr_i == `PRS_OFF_CSW) begin
			cur = {24'h00_0000, q.csw};
		end else if (adr_i == `PRS_OFF_STP) begin
			cur = {16'h0000, q.stp};
		end else if (adr_i >= `PRS_OFF_GPR && adr_i < 8'h30 && adr_i[1:0] == 2'b00) begin
			cur = {24'h00_0000, q.gpr[bidx]};
		end else if (adr_i >= `PRS_OFF_PAIR && adr_i < `PRS_OFF_DEC && adr_i[1:0] == 2'b00) begin
			cur = {16'h0000, pair_rd(q.gpr, pidx)};
		end else if (adr_i == `PRS_OFF_DEC) begin
			cur = {21'h00_0000, q.sfr_off, q.region};
		end else if (adr_i == `PRS_OFF_DADDR) begin
			cur = {16'h0000, q.daddr};
		end else begin
			hit = 1'b0;
		end
		rdata = cur;
		// bus slave: answer one cycle after the request is seen, then drop
		case (q.bus)
			PRS_IDLE: begin
				if (cyc_i && stb_i) begin
					next_q.bus = PRS_ACK;
					next_q.err = !hit;
					next_q.dat = we_i ? 32'h0000_0000 : rdata;
				end
			end
			PRS_ACK: begin
				next_q.bus = PRS_IDLE;
				next_q.err = 1'b0;
				next_q.dat = 32'h0000_0000;
				// write takes effect at the acknowledging edge
				if (cyc_i && stb_i && we_i && hit) begin
					if (adr_i == `PRS_OFF_NIA) begin
						next_q.nia = (cur[15:0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
					end else if (adr_i == `PRS_OFF_CSW) begin
						next_q.csw = (q.csw & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
					end else if (adr_i == `PRS_OFF_STP) begin
						// no range check: software keeps it in fast RAM
						next_q.stp = (cur[15:0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
					end else if (adr_i >= `PRS_OFF_GPR && adr_i < 8'h30) begin
						if (sel_i[0]) begin
							next_q.gpr[bidx] = dat_i[7:0];
						end
					end else if (adr_i >= `PRS_OFF_PAIR && adr_i < `PRS_OFF_DEC) begin
						if (sel_i[0]) begin
							next_q.gpr[{pidx, 1'b0}] = dat_i[7:0];
						end
						if (sel_i[1]) begin
							next_q.gpr[{pidx, 1'b1}] = dat_i[15:8];
						end
					end else if (adr_i == `PRS_OFF_DADDR) begin
						next_q.daddr = (cur[15:0] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
					end
				end
			end
			default: begin
				next_q.bus = PRS_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state register; stack pointer and general registers keep no reset
	always_ff @(posedge clk_i) begin
		q <= next_q;
		if (rst_i) begin
			q.nia <= `PRS_NIA_RST;
			q.csw <= `PRS_CSW_RST;
			q.bus <= PRS_IDLE;
			q.dat <= 32'h0000_0000;
			q.err <= 1'b0;
			q.daddr <= 16'h0000;
			q.rd_byte <= 16'h0000;
			q.rd_pair <= 16'h0000;
			q.region <= PRS_REG_NONE;
			q.sfr_off <= 8'h00;
			// stack pointer deliberately not reset: software must load it
			q.stp <= next_q.stp;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	assign dat_o = q.dat;
	assign ack_o = q.bus[1]; // one-hot ack state bit, no decode after the flop
	assign err_o = q.err;
	assign nia_o = q.nia;
	assign csw_o = q.csw;
	assign stp_o = q.stp;
	assign irq_accept_flag_o = q.csw[`PRS_CSW_IE];
	assign rd_byte_o = q.rd_byte;
	assign rd_pair_o = q.rd_pair;
	assign region_o = q.region;
	assign sfr_off_o = q.sfr_off;
endmodule // prs_regset

//--- testbench/prs_regset_checker.sv
`timescale 1ns/10ps
module prs_regset_checker
	import prs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus and datapath
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_o,
	input wire logic err_o,
	input wire prs_upd_s upd_i,
	input wire logic [15:0] nia_o,
	input wire logic [7:0] csw_o,
	input wire logic [15:0] stp_o,
	input wire logic irq_accept_flag_o,
	input wire prs_region_e region_o
);
	// ==========
	// helpers: nibble carry, and a bus write that would win the edge
	logic [4:0] nib;
	logic dp;
	assign nib = upd_i.sub ? 5'(upd_i.nib_a) - 5'(upd_i.nib_b) : 5'(upd_i.nib_a) + 5'(upd_i.nib_b);
	assign dp = !(ack_o && we_i);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// bus handshake steps
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_ans; ack_o ##1 !ack_o; endsequence
	property p_bus; s_req |=> s_ans; endproperty
	property p_err; err_o |-> ack_o; endproperty
	property p_irq; upd_i.ie_we && dp |=> irq_accept_flag_o == $past(upd_i.ie); endproperty
	property p_zero; upd_i.flag_we && dp |=> csw_o[6] == ($past(upd_i.result[7:0]) == 8'h00);
	endproperty
	property p_half; upd_i.flag_we && dp |=> csw_o[4] == $past(nib[4]); endproperty
	property p_carry; upd_i.flag_we && dp |=> csw_o[0] == $past(upd_i.result[8]); endproperty
	property p_next; upd_i.nia_we && dp |=> nia_o == $past(upd_i.nia); endproperty
	property p_stack; upd_i.stp_we && dp |=> stp_o == $past(upd_i.stp); endproperty
	property p_region; $onehot(region_o); endproperty
	a_bus: assert property (p_bus) else $error("ack late or long");
	a_err: assert property (p_err) else $error("err without ack");
	a_irq: assert property (p_irq) else $error("irq flag differs");
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	a_half: assert property (p_half) else $error("half carry wrong");
	a_carry: assert property (p_carry) else $error("carry wrong");
	a_next: assert property (p_next) else $error("next address wrong");
	a_stack: assert property (p_stack) else $error("stack pointer wrong");
	a_region: assert property (p_region) else $error("region not one-hot");
endmodule // prs_regset_checker
bind prs_regset prs_regset_checker prs_regset_checker_inst (.*);

//--- testbench/prs_dp_model.sv
`timescale 1ns/10ps
module prs_dp_model
	import prs_pkg::*;
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire prs_upd_s cmd_i,
	output prs_upd_s upd_o
);
	prs_upd_s cmd_fix;
	// stack always lands in fast ram
	always_comb begin
		cmd_fix = cmd_i;
		cmd_fix.stp = {9'h1FD, cmd_i.stp[6:0]};
	end
	// one-cycle update pulse, a single assignment per edge
	always_ff @(posedge clk_i) begin
		upd_o <= go_i ? cmd_fix : '0;
	end
endmodule // prs_dp_model

//--- testbench/prs_regset_tb.sv
`timescale 1ns/10ps
`include "prs_defs.svh"
module prs_regset_tb import prs_pkg::*; ;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_accept_flag_o, go;
	logic [7:0] adr_i, csw_o, sfr_off_o;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, s;
	logic [2:0] rd_idx_i, rg;
	logic [1:0] rd_pidx_i;
	logic [15:0] nia_o, stp_o, rd_byte_o, rd_pair_o;
	logic [15:0] da [5] = '{16'hFE7F, 16'hFE80, 16'hFEFF, 16'hFF00, 16'hFFFF};
	logic [7:0] r [8];
	logic [4:0] n;
	logic [33:0] x;
	logic [33:0] q [$];
	prs_upd_s cmd, upd_i;
	prs_region_e region_o;
	int err_total, num_checks;
	prs_regset prs_regset_inst (.*);
	prs_dp_model prs_dp_model_inst (.clk_i(clk_i), .go_i(go), .cmd_i(cmd), .upd_o(upd_i));
	// ==========
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// classic single cycle; the expected answer is queued first
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		q.push_back({w, e});
		do @(posedge clk_i); while (ack_o !== 1'b1);
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic dp(input prs_upd_s c);
		@(posedge clk_i);
		cmd <= c;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========
	// answers are judged in the ack cycle; write data is not looked at
	always @(posedge clk_i) begin
		if (ack_o === 1'b1) begin
			x = q.pop_front();
			cmp({x[33], err_o, x[33] ? x[31:0] : dat_o}, x);
		end
	end
	initial begin
		#100000;
		err_total++;
		results();
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, go} = 5'h10;
		{adr_i, dat_i, rd_idx_i, rd_pidx_i} = '0;
		sel_i = 4'hF;
		cmd = '0;
		s = 32'h5F53;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `PRS_OFF_NIA, 32'h0, 33'h0);
		wb(0, `PRS_OFF_CSW, 32'h0, 33'h2);
		wb(0, 8'h4C, 32'h0, 33'h100000000);
		wb(1, `PRS_OFF_CSW, 32'hD1, 33'h0);
		wb(0, `PRS_OFF_CSW, 32'h0, 33'hD1);
		for (int i = 0; i < 8; i++) begin
			r[i] = 8'(xs());
			wb(1, 8'(`PRS_OFF_GPR + 4 * i), {24'h0, r[i]}, 33'h0);
		end
		for (int i = 0; i < 8; i++) begin
			wb(0, 8'(`PRS_OFF_GPR + 4 * i), 32'h0, {25'h0, r[i]});
			if (i < 4) wb(0, 8'(`PRS_OFF_PAIR + 4 * i), 32'h0, {17'h0, r[2 * i + 1], r[2 * i]});
			rd_idx_i <= 3'(i);
			rd_pidx_i <= 2'(i >> 1);
			@(posedge clk_i);
			#1;
			cmp({rd_pair_o, rd_byte_o, 2'b00}, {r[i | 1], r[i & 6], 8'h00, r[i], 2'b00});
		end
		// datapath pair write lands in two byte registers
		cmd = '0;
		{cmd.gpr_we, cmd.wide, cmd.idx, cmd.wdata} = {2'b11, 3'h2, 16'hA55A};
		dp(cmd);
		wb(0, 8'(`PRS_OFF_GPR + 16), 32'h0, 33'h5A);
		wb(0, 8'(`PRS_OFF_GPR + 20), 32'h0, 33'hA5);
		for (int k = 0; k < 6; k++) begin
			cmd = '0;
			{cmd.result, cmd.nib_a, cmd.nib_b} = 17'(xs());
			if (k < 2) cmd.result = 9'h100;
			{cmd.flag_we, cmd.ie_we, cmd.nia_we, cmd.stp_we, cmd.sub, cmd.ie} = {4'hF, k[0], k[1]};
			{cmd.nia, cmd.stp} = xs();
			n = cmd.sub ? 5'(cmd.nib_a) - 5'(cmd.nib_b) : 5'(cmd.nib_a) + 5'(cmd.nib_b);
			dp(cmd);
			cmp({csw_o[7:6], csw_o[4], csw_o[0], irq_accept_flag_o}, {cmd.ie, cmd.result[7:0] == 8'h00, n[4], cmd.result[8], cmd.ie});
			cmp({nia_o, stp_o}, {cmd.nia, 9'h1FD, cmd.stp[6:0]});
		end
		// data address classes at every boundary of the window
		for (int k = 0; k < 5; k++) begin
			rg = da[k] >= `PRS_SFR_LO ? 3'h4 : da[k] >= `PRS_RAM_LO ? 3'h2 : 3'h1;
			wb(1, `PRS_OFF_DADDR, {16'h0, da[k]}, 33'h0);
			wb(0, `PRS_OFF_DEC, 32'h0, {22'h0, da[k][7:0], rg});
			cmp({23'h0, sfr_off_o, region_o}, {23'h0, da[k][7:0], rg});
		end
		results();
	end
endmodule // prs_regset_tb
